// File: verilog/lbp_pkg.sv
// Constants shared by the bypass-switch dimming control block
`default_nettype none
package lbp_pkg;
    localparam int unsigned DUTY_W = 12;
    localparam int unsigned CTRL_W = 13;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CFG_W = 8;
    localparam int unsigned NUM_CH = 2;

    // Register offsets
    localparam logic [7:0] RUN_CTRL_OFS = 8'h01;
    localparam logic [7:0] CONFIG_OFS = 8'h02;
    localparam logic [7:0] CH4_DIMMING_CTRL_OFS = 8'h21;
    localparam logic [7:0] CH5_DIMMING_CTRL_OFS = 8'h22;

    // Field positions
    localparam int unsigned FADE_BIT = 12;
    localparam int unsigned DUTY_MSB = 11;
    localparam int unsigned RUN_BIT = 0;

    // Reset values
    localparam logic [12:0] DIMMING_CTRL_RST = 13'h0000;
    localparam logic [7:0] CONFIG_RST = 8'h00;

    // Duty encodings: zero is dark, all ones is fully on
    localparam logic [11:0] DUTY_OFF = 12'h000;
    localparam logic [11:0] DUTY_FULL = 12'hfff;

    // Phase counter wraps after DUTY_FULL counts, so one count is 1/4095
    localparam logic [11:0] PHASE_LAST = 12'hffe;
    localparam logic [11:0] PHASE_FIRST = 12'h000;

    // Duty change per PWM period while fading
    localparam logic [11:0] FADE_STEP = 12'h010;
endpackage : lbp_pkg
`default_nettype wire

// File: verilog/lbp_channel.sv
// One dimming channel: duty latch, fade stepping and PWM compare
`timescale 1ns/1ps
`default_nettype none
module lbp_channel
    import lbp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Shared phase
    input wire logic run,
    input wire logic period_start,
    input wire logic [DUTY_W-1:0] phase,
    // Settings
    input wire logic [DUTY_W-1:0] target_duty,
    input wire logic fade_en,
    // Switch drive
    output logic pwm_on
);
    logic [DUTY_W-1:0] active_duty;
    logic [DUTY_W-1:0] next_active_duty;
    logic [DUTY_W-1:0] faded_duty;
    logic [DUTY_W-1:0] eff_duty;
    logic [DUTY_W-1:0] diff_up;
    logic [DUTY_W-1:0] diff_dn;

    assign diff_up = target_duty - active_duty;
    assign diff_dn = active_duty - target_duty;

    // Fading walks toward the target one step per period
    assign faded_duty = (target_duty > active_duty) ?
                        ((diff_up > FADE_STEP) ? active_duty + FADE_STEP : target_duty) :
                        ((diff_dn > FADE_STEP) ? active_duty - FADE_STEP : target_duty); // [R2] [R3]

    // Changes only land on a period boundary so no pulse is cut short
    assign next_active_duty = !period_start ? active_duty :
                              (fade_en ? faded_duty : target_duty); // [R10]
    assign eff_duty = next_active_duty;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            active_duty <= DUTY_OFF;
            pwm_on <= 1'b0;
        end else begin
            active_duty <= next_active_duty;
            // Full scale exceeds the last phase, so it never turns off
            pwm_on <= run && (phase < eff_duty); // [R1] [R4]
        end
    end
endmodule // lbp_channel
`default_nettype wire

// File: verilog/lbp_ctrl.sv
// Dimming registers, run enable and shared PWM phase for channels 4 and 5
// How it works
// [R1] Channel 5 duty: 12 bits, zero dark, ones full.
// [R2] Channel 5 bit 12 enables gradual fade.
// [R3] Channel 4 bit 12 enables gradual fade.
// [R4] Channel 4 duty bits 11:0, same scale.
// [R5] Channel 5 control at 0x22, RW, resets zero.
// [R6] Host programs configuration at 0x02 first.
// [R7] Configuration writable only while run enable clear.
// [R8] Run clear resets phase; setting restarts it.
// [R9] Host sets run bits by broadcast together.
// [R10] Unfaded duty change lands at next period.
`timescale 1ns/1ps
`default_nettype none
module lbp_ctrl
    import lbp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register access from the serial frame decoder
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_wr_rejected,
    // Device state
    output logic switch_run_enable,
    output logic [CFG_W-1:0] config_q,
    output logic [NUM_CH-1:0] switch_pwm
);
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    logic [CTRL_W-1:0] ch4_dimming_ctrl;
    logic [CTRL_W-1:0] ch5_dimming_ctrl;
    logic [DUTY_W-1:0] phase;
    logic [DUTY_W-1:0] next_phase;
    logic [DATA_W-1:0] next_rdata;
    logic [DUTY_W-1:0] duty [NUM_CH];
    logic fade [NUM_CH];
    logic sel_run;
    logic sel_cfg;
    logic sel_ch4;
    logic sel_ch5;
    logic wr_run;
    logic wr_cfg;
    logic wr_cfg_ok;
    logic wr_ch4;
    logic wr_ch5;
    logic period_start;
    logic phase_wrap;
    logic [DATA_W-1:0] run_word;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] ch4_word;
    logic [DATA_W-1:0] ch5_word;
    logic [CTRL_W-1:0] ctrl_word [NUM_CH];

    // Address decode, shared by the write strobes and the read mux
    assign sel_run = hit(reg_addr, RUN_CTRL_OFS);
    assign sel_cfg = hit(reg_addr, CONFIG_OFS);
    assign sel_ch4 = hit(reg_addr, CH4_DIMMING_CTRL_OFS);
    assign sel_ch5 = hit(reg_addr, CH5_DIMMING_CTRL_OFS); // [R5]

    assign wr_run = reg_wr && sel_run;
    assign wr_cfg = reg_wr && sel_cfg;
    // Slew and threshold settings must not shift under running switches
    assign wr_cfg_ok = wr_cfg && !switch_run_enable; // [R7]
    assign wr_ch4 = reg_wr && sel_ch4;
    assign wr_ch5 = reg_wr && sel_ch5; // [R5]

    // Phase held at its first count while stopped, so a broadcast start aligns devices
    assign phase_wrap = (phase == PHASE_LAST);
    assign next_phase = !switch_run_enable ? PHASE_FIRST :
                        phase_wrap ? PHASE_FIRST : phase + 12'h001; // [R8]
    assign period_start = switch_run_enable && (phase == PHASE_FIRST);

    // Readback words; bits above each field read as zero
    assign run_word = {{(DATA_W-1){1'b0}}, switch_run_enable};
    assign cfg_word = {{(DATA_W-CFG_W){1'b0}}, config_q};
    assign ch4_word = {{(DATA_W-CTRL_W){1'b0}}, ch4_dimming_ctrl};
    assign ch5_word = {{(DATA_W-CTRL_W){1'b0}}, ch5_dimming_ctrl};

    // Unmapped addresses read zero rather than aliasing a neighbour
    assign next_rdata = sel_run ? run_word :
                        sel_cfg ? cfg_word :
                        sel_ch4 ? ch4_word :
                        sel_ch5 ? ch5_word :
                        {DATA_W{1'b0}};

    // One short block per register keeps each write enable plain to read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch4_dimming_ctrl <= DIMMING_CTRL_RST;
        end else if (wr_ch4) begin
            ch4_dimming_ctrl <= reg_wdata[CTRL_W-1:0]; // [R3] [R4]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch5_dimming_ctrl <= DIMMING_CTRL_RST; // [R5]
        end else if (wr_ch5) begin
            ch5_dimming_ctrl <= reg_wdata[CTRL_W-1:0]; // [R1] [R2]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            switch_run_enable <= 1'b0;
        end else if (wr_run) begin
            switch_run_enable <= reg_wdata[RUN_BIT]; // [R8]
        end
    end

    // A refused write leaves the stored value untouched
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            config_q <= CONFIG_RST;
        end else if (wr_cfg_ok) begin
            config_q <= reg_wdata[CFG_W-1:0]; // [R7]
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= PHASE_FIRST;
        end else begin
            phase <= next_phase; // [R8]
        end
    end

    // Read data holds until the next read so a slow frame encoder can fetch it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= {DATA_W{1'b0}};
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_wr_rejected <= 1'b0;
        end else begin
            reg_wr_rejected <= wr_cfg && switch_run_enable; // [R7]
        end
    end

    // Channel 4 sits in slot 0 and channel 5 in slot 1 of the switch outputs
    assign ctrl_word[0] = ch4_dimming_ctrl;
    assign ctrl_word[1] = ch5_dimming_ctrl;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_field
        assign duty[i] = ctrl_word[i][DUTY_MSB:0]; // [R1] [R4]
        assign fade[i] = ctrl_word[i][FADE_BIT]; // [R2] [R3]
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        lbp_channel u_ch (
            .clk(clk),
            .arst_n(arst_n),
            .run(switch_run_enable),
            .period_start(period_start),
            .phase(phase),
            .target_duty(duty[i]),
            .fade_en(fade[i]),
            .pwm_on(switch_pwm[i])
        );
    end
endmodule // lbp_ctrl
`default_nettype wire

// File: sim/lbp_ctrl_asserts.sv
// Port checks for the dimming control block
`timescale 1ns/1ps
`default_nettype none
module lbp_ctrl_asserts
    import lbp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_wr_rejected,
    // Device state
    input wire logic switch_run_enable,
    input wire logic [CFG_W-1:0] config_q,
    input wire logic [NUM_CH-1:0] switch_pwm
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire cfg_wr = reg_wr && reg_addr == CONFIG_OFS;
    wire mapped = reg_addr inside {RUN_CTRL_OFS, CONFIG_OFS, CH4_DIMMING_CTRL_OFS, CH5_DIMMING_CTRL_OFS};
    read_ack_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
    cfg_lock_a: assert property (cfg_wr && switch_run_enable |=> reg_wr_rejected && $stable(config_q))
        else $error("config written while running");
    cfg_take_a: assert property (cfg_wr && !switch_run_enable |=> config_q == $past(reg_wdata[7:0]))
        else $error("config write lost");
    cfg_hold_a: assert property (!cfg_wr |=> $stable(config_q)) else $error("config changed");
    reject_why_a: assert property (reg_wr_rejected |-> $past(cfg_wr && switch_run_enable))
        else $error("spurious reject");
    run_take_a: assert property (reg_wr && reg_addr == RUN_CTRL_OFS |=> switch_run_enable == $past(reg_wdata[0]))
        else $error("run bit not taken");
    run_dark_a: assert property (!switch_run_enable |=> switch_pwm == 2'h0) else $error("switch on while stopped");
    unmapped_zero_a: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000) else $error("unmapped read");
    ch5_width_a: assert property (reg_rd && reg_addr == CH5_DIMMING_CTRL_OFS |=> reg_rdata[15:13] == 3'h0)
        else $error("ch5 upper bits");
endmodule // lbp_ctrl_asserts
`default_nettype wire

// File: sim/lbp_host.sv
// Host stand-in issuing decoded register accesses
`timescale 1ns/1ps
`default_nettype none
module lbp_host
    import lbp_pkg::*;
(
    input wire logic clk,
    output logic wr,
    output logic rd,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata
);
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 16'h0000;
    end
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] v);
        repeat ($urandom % 3) @(negedge clk);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wdata = v;
        @(negedge clk);
        wr = 1'b0;
        rd = 1'b0;
        // Released lines show garbage so stale values cannot pass
        addr = ~a;
        wdata = ~v;
    endtask
endmodule // lbp_host
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the dimming control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lbp_pkg::*;
    logic clk = 0;
    logic arst_n = 0;
    logic wr, rd, rv, rej, run;
    logic [7:0] addr, cfg;
    logic [15:0] wdata, rdata;
    logic [1:0] pwm;
    int n_fail = 0, samples_checked = 0, cyc = 0, c4, c5, d;
    int mdl [256];
    always #2.5 clk = ~clk;
    lbp_ctrl dut (.clk(clk), .arst_n(arst_n), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .reg_rvalid(rv), .reg_wr_rejected(rej), .switch_run_enable(run), .config_q(cfg),
        .switch_pwm(pwm));
    lbp_host host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(string s, logic [15:0] e, logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rdall(string s);
        for (int a = 0; a < 36; a++) begin
            host.acc(1'b0, 8'(a), 16'h0000);
            chk("rvalid", 16'h0001, 16'(rv));
            chk("rdata", 16'(mdl[a]), rdata);
        end
        $display("%s done", s);
    endtask
    task automatic wrm(logic [7:0] a, logic [15:0] v);
        host.acc(1'b1, a, v);
        if (a == CONFIG_OFS && mdl[1] != 0) chk("reject", 16'h0001, 16'(rej));
        else if (a inside {RUN_CTRL_OFS, CONFIG_OFS, CH4_DIMMING_CTRL_OFS, CH5_DIMMING_CTRL_OFS})
            mdl[a] = int'(v & (a == RUN_CTRL_OFS ? 16'h0001 : a == CONFIG_OFS ? 16'h00ff : 16'h1fff));
    endtask
    // Any 4095-cycle window holds exactly one period while the duty is steady
    task automatic cnt(output int a, output int b);
        a = 0;
        b = 0;
        repeat (4095) begin
            @(negedge clk);
            a += int'(pwm[0]);
            b += int'(pwm[1]);
        end
    endtask
    initial begin
        d = $urandom(32'h04ae0b87);
        repeat (3) @(negedge clk);
        arst_n = 1;
        rdall("reset");
        wrm(CONFIG_OFS, 16'($urandom));
        wrm(CH4_DIMMING_CTRL_OFS, 16'he001);
        wrm(CH5_DIMMING_CTRL_OFS, 16'h0fff);
        rdall("setup");
        wrm(RUN_CTRL_OFS, 16'h0001);
        @(negedge clk);
        chk("restart", 16'h0001, 16'(pwm[0]));
        wrm(CONFIG_OFS, 16'($urandom));
        cnt(c4, c5);
        chk("ch4 duty one", 16'd1, 16'(c4));
        chk("ch5 full", 16'd4095, 16'(c5));
        $display("start done");
        wrm(CH5_DIMMING_CTRL_OFS, 16'h0000);
        repeat (3) @(negedge clk);
        chk("duty held", 16'h0001, 16'(pwm[1]));
        d = $urandom & 32'h7ff;
        wrm(CH4_DIMMING_CTRL_OFS, 16'(d));
        repeat (4096) @(negedge clk);
        cnt(c4, c5);
        chk("ch4 random", 16'(d), 16'(c4));
        chk("ch5 dark", 16'd0, 16'(c5));
        $display("duty done");
        wrm(CH4_DIMMING_CTRL_OFS, 16'h1fff);
        wrm(CH5_DIMMING_CTRL_OFS, 16'h1fff);
        repeat (4096) @(negedge clk);
        cnt(c4, c5);
        chk("ch4 fading", 16'h0001, 16'(c4 > d && c4 < 4095));
        chk("ch5 fading", 16'h0001, 16'(c5 > 0 && c5 < 4095));
        $display("fade done");
        wrm(RUN_CTRL_OFS, 16'h0000);
        @(negedge clk);
        chk("dark", 16'h0000, 16'(pwm));
        rdall("stop");
        results();
    end
endmodule // testbench
bind lbp_ctrl lbp_ctrl_asserts chk (.*);
`default_nettype wire
